// [verilog/opcode_decoder.sv]
// opcode decoder: collects instruction bytes from the prefetch queue and decodes them
`timescale 1ns/1ns

// Behaviour
// - sum family with register and register-or-memory operands; direction and width bits
// - second immediate byte only for sign/size 01, or word accumulator forms
// - minus families with register-or-memory operands honour direction and width bits
// - one opcode with width bit; extension 100 unsigned, 101 signed product
// - same opcode; extension 110 unsigned, 111 signed quotient
// - ascii product fix is two bytes, second byte fixed
// - ascii quotient fix is two bytes with the same fixed second byte
// - single-byte bcd fix after subtraction, no addressing byte
// - single byte widens low accumulator byte to full accumulator
// - single byte widens accumulator into accumulator and data register
// - single-byte ascii and bcd fixes after addition, no operand bytes
// - single-byte ascii fix after subtraction, no operand bytes
// - single-byte table lookup indexed by low accumulator byte
// - effective-address load writes the address into the selected register
// - far-pointer loads into a register and data or extra segment
// - single-byte transfers between low flags and high accumulator byte
// - segment copies both ways, segment chosen by the addressing byte
// - width bit set means word, clear means byte
// - sign/size 11 sign-extends the single immediate byte
// - addressing form 11 makes the operand locator a register selector
module opcode_decoder
  import cpu_decode_pkg::*;
#(
  parameter int unsigned LEN_W = 3
) (
  input  wire logic                   ref_clk,
  input  wire logic                   reset_n,
  input  wire logic                   byte_valid,
  input  wire logic [7:0]             byte_data,
  output logic                        byte_ready,
  output logic                        inst_valid,
  output cpu_decode_pkg::op_e         inst_op,
  output logic                        size_sel,
  output logic                        to_reg_flag,
  output logic                        rm_is_reg,
  output logic [1:0]                  addr_form_field,
  output logic [2:0]                  gpr_select_field,
  output logic [2:0]                  operand_locator_field,
  output logic [1:0]                  seg_sel,
  output logic [15:0]                 disp_value,
  output logic [15:0]                 imm_value,
  output logic                        imm_sign_extended,
  output logic [LEN_W-1:0]            inst_len
);
  import cpu_decode_pkg::*;

  if (LEN_W < 3 || (2 ** LEN_W) <= MAX_INST_LEN) begin : g_len_check
    $error("LEN_W too narrow for the longest instruction");
  end

  typedef enum logic [2:0] {
    ST_OPCODE  = 3'h0,
    ST_MODRM   = 3'h1,
    ST_DISP_LO = 3'h3,
    ST_DISP_HI = 3'h2,
    ST_IMM_LO  = 3'h6,
    ST_IMM_HI  = 3'h7,
    ST_EMIT    = 3'h5
  } dec_st_e;

  typedef struct packed {
    dec_st_e           st;
    logic              ready;
    logic              valid;
    logic [7:0]        opcode;
    logic [7:0]        modrm;
    op_e               op;
    logic              size_sel;
    logic              to_reg;
    logic              sext;
    logic              rm_is_reg;
    logic [1:0]        disp_len;
    logic [1:0]        imm_len;
    logic [15:0]       disp;
    logic [15:0]       imm;
    logic [LEN_W-1:0]  len;
  } dec_state_s;

  dec_state_s s_r;
  dec_state_s s_nxt;
  logic       take;

  opcode_class_if cls ();

  opcode_classifier u_classifier (
    .cls (cls)
  );

  assign take       = byte_valid && s_r.ready;
  assign cls.opcode = (s_r.st == ST_OPCODE) ? byte_data : s_r.opcode;
  assign cls.modrm  = (s_r.st == ST_MODRM) ? byte_data : s_r.modrm;

  // next state once the addressing byte (or the opcode) is consumed
  function automatic dec_st_e tail_st(input logic [1:0] dl, input logic [1:0] il);
    dec_st_e t;
    if (dl != LEN_NONE) begin
      t = ST_DISP_LO;
    end else if (il != LEN_NONE) begin
      t = ST_IMM_LO;
    end else begin
      t = ST_EMIT;
    end
    return t;
  endfunction

  always_comb begin
    s_nxt       = s_r;
    s_nxt.valid = 1'b0;
    unique case (s_r.st)
      ST_OPCODE: begin
        if (take) begin
          s_nxt.opcode    = byte_data;
          s_nxt.modrm     = 8'h00;
          s_nxt.disp      = 16'h0000;
          s_nxt.imm       = 16'h0000;
          s_nxt.len       = LEN_W'(1);
          s_nxt.op        = cls.op;
          s_nxt.size_sel  = cls.size_sel;
          s_nxt.to_reg    = cls.to_reg;
          s_nxt.sext      = cls.sext;
          s_nxt.imm_len   = cls.imm_len;
          s_nxt.disp_len  = LEN_NONE;
          s_nxt.rm_is_reg = 1'b0;
          // the fixed second byte of the ascii fixes rides in the addressing slot
          if (cls.needs_modrm || cls.fixed_second) begin
            s_nxt.st = ST_MODRM;
          end else begin
            s_nxt.st = tail_st(LEN_NONE, cls.imm_len);
          end
        end
      end
      ST_MODRM: begin
        if (take) begin
          s_nxt.modrm     = byte_data;
          s_nxt.len       = s_r.len + LEN_W'(1);
          s_nxt.op        = cls.op;
          s_nxt.disp_len  = cls.disp_len;
          s_nxt.rm_is_reg = cls.rm_is_reg;
          s_nxt.st        = tail_st(cls.disp_len, s_r.imm_len);
        end
      end
      ST_DISP_LO: begin
        if (take) begin
          // short displacement is sign-extended; the high byte overwrites it if present
          s_nxt.disp = {{8{byte_data[7]}}, byte_data};
          s_nxt.len  = s_r.len + LEN_W'(1);
          s_nxt.st   = (s_r.disp_len == LEN_TWO) ? ST_DISP_HI : tail_st(LEN_NONE, s_r.imm_len);
        end
      end
      ST_DISP_HI: begin
        if (take) begin
          s_nxt.disp[15:8] = byte_data;
          s_nxt.len        = s_r.len + LEN_W'(1);
          s_nxt.st         = tail_st(LEN_NONE, s_r.imm_len);
        end
      end
      ST_IMM_LO: begin
        if (take) begin
          s_nxt.imm = s_r.sext ? {{8{byte_data[7]}}, byte_data} : {8'h00, byte_data};
          s_nxt.len = s_r.len + LEN_W'(1);
          s_nxt.st  = (s_r.imm_len == LEN_TWO) ? ST_IMM_HI : ST_EMIT;
        end
      end
      ST_IMM_HI: begin
        if (take) begin
          s_nxt.imm[15:8] = byte_data;
          s_nxt.len       = s_r.len + LEN_W'(1);
          s_nxt.st        = ST_EMIT;
        end
      end
      ST_EMIT: s_nxt.st = ST_OPCODE;
      default: s_nxt.st = ST_OPCODE;
    endcase
    // no output buffer: the queue is held off for the one cycle a result is shown
    s_nxt.valid = (s_nxt.st == ST_EMIT);
    s_nxt.ready = (s_nxt.st != ST_EMIT);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign byte_ready            = s_r.ready;
  assign inst_valid            = s_r.valid;
  assign inst_op               = s_r.op;
  assign size_sel              = s_r.size_sel;
  assign to_reg_flag           = s_r.to_reg;
  assign rm_is_reg             = s_r.rm_is_reg;
  assign addr_form_field       = s_r.modrm[7:6];
  assign gpr_select_field      = s_r.modrm[5:3];
  assign operand_locator_field = s_r.modrm[2:0];
  assign seg_sel               = s_r.modrm[4:3];
  assign disp_value            = s_r.disp;
  assign imm_value             = s_r.imm;
  assign imm_sign_extended     = s_r.sext;
  assign inst_len              = s_r.len;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_take_op(logic [7:0] b);
    take && s_r.st == ST_OPCODE && byte_data == b;
  endsequence

  sequence s_take_next(logic [7:0] b);
    take && s_r.st != ST_OPCODE && byte_data == b;
  endsequence

  property p_sum_dir;
    s_take_op(8'h03) ##1 s_take_next(8'hC0) |=>
      inst_valid && inst_op == OP_SUM && to_reg_flag && size_sel && inst_len == 3'd2;
  endproperty
  a_sum_dir: assert property (p_sum_dir) else $error("sum form misdecoded");

  property p_imm_rm_len;
    inst_valid && s_r.opcode == 8'h81 && rm_is_reg |-> inst_len == 3'd4;
  endproperty
  a_imm_rm_len: assert property (p_imm_rm_len) else $error("word immediate length wrong");

  property p_imm_acc_len;
    inst_valid && s_r.opcode[7:1] == 7'h02 |-> inst_len == (s_r.opcode[0] ? 3'd3 : 3'd2);
  endproperty
  a_imm_acc_len: assert property (p_imm_acc_len) else $error("accumulator imm length wrong");

  property p_minus;
    s_take_op(8'h2B) ##1 s_take_next(8'hC0) |=>
      inst_valid && inst_op == OP_MINUS && to_reg_flag && size_sel;
  endproperty
  a_minus: assert property (p_minus) else $error("minus form misdecoded");

  property p_uprod;
    s_take_op(8'hF7) ##1 s_take_next(8'hE0) |=>
      inst_valid && inst_op == OP_UNSIGNED_PRODUCT && size_sel && inst_len == 3'd2;
  endproperty
  a_uprod: assert property (p_uprod) else $error("unsigned product misdecoded");

  property p_squot;
    s_take_op(8'hF6) ##1 s_take_next(8'hF8) |=>
      inst_valid && inst_op == OP_SIGNED_QUOTIENT && !size_sel;
  endproperty
  a_squot: assert property (p_squot) else $error("signed quotient misdecoded");

  property p_ascii_prod;
    s_take_op(8'hD4) ##1 s_take_next(8'h0A) |=>
      inst_valid && inst_op == OP_ASCII_PRODUCT_FIX && inst_len == 3'd2;
  endproperty
  a_ascii_prod: assert property (p_ascii_prod) else $error("ascii product fix wrong");

  property p_ascii_quot;
    s_take_op(8'hD5) ##1 s_take_next(8'h0A) |=>
      inst_valid && inst_op == OP_ASCII_QUOTIENT_FIX && inst_len == 3'd2;
  endproperty
  a_ascii_quot: assert property (p_ascii_quot) else $error("ascii quotient fix wrong");

  property p_bcd_minus;
    s_take_op(8'h2F) |=> inst_valid && inst_op == OP_BCD_MINUS_FIX && inst_len == 3'd1;
  endproperty
  a_bcd_minus: assert property (p_bcd_minus) else $error("bcd minus fix wrong");

  property p_byte_widen;
    s_take_op(8'h98) |=> inst_valid && inst_op == OP_BYTE_SIGN_WIDEN && inst_len == 3'd1;
  endproperty
  a_byte_widen: assert property (p_byte_widen) else $error("byte widen wrong");

  property p_word_widen;
    s_take_op(8'h99) |=> inst_valid && inst_op == OP_WORD_SIGN_WIDEN && inst_len == 3'd1;
  endproperty
  a_word_widen: assert property (p_word_widen) else $error("word widen wrong");

  property p_size;
    inst_valid && s_r.opcode[7:2] == 6'h00 |-> size_sel == s_r.opcode[0];
  endproperty
  a_size: assert property (p_size) else $error("width bit not honoured");

  property p_sext;
    inst_valid && s_r.opcode == 8'h83 |-> imm_value[15:8] == {8{imm_value[7]}};
  endproperty
  a_sext: assert property (p_sext) else $error("immediate not sign-extended");

  property p_reg_sel;
    inst_valid && rm_is_reg |-> addr_form_field == 2'h3 && disp_value == 16'h0000;
  endproperty
  a_reg_sel: assert property (p_reg_sel) else $error("register form took displacement");

  property p_emit_gap;
    inst_valid |-> !byte_ready ##1 (byte_ready && !inst_valid);
  endproperty
  a_emit_gap: assert property (p_emit_gap) else $error("result cycle handshake wrong");

endmodule

// [verilog/cpu_decode_pkg.sv]
// package: opcode encodings, field positions and operation classes of the decoder
package cpu_decode_pkg;

  typedef enum logic [4:0] {
    OP_ILLEGAL, OP_SUM, OP_SUM_CARRY, OP_MINUS, OP_MINUS_BORROW, OP_COMPARE,
    OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_UNSIGNED_QUOTIENT, OP_SIGNED_QUOTIENT,
    OP_ASCII_PRODUCT_FIX, OP_ASCII_QUOTIENT_FIX, OP_ASCII_SUM_FIX, OP_BCD_SUM_FIX,
    OP_ASCII_MINUS_FIX, OP_BCD_MINUS_FIX, OP_BYTE_SIGN_WIDEN, OP_WORD_SIGN_WIDEN,
    OP_TABLE_LOOKUP, OP_EFF_ADDR_LOAD, OP_FAR_PTR_LOAD_DATA_SEG,
    OP_FAR_PTR_LOAD_EXTRA_SEG, OP_FLAGS_TO_HIGH_ACC, OP_HIGH_ACC_TO_FLAGS,
    OP_COPY_SEG_TO_RM, OP_COPY_RM_TO_SEG
  } op_e;

  // field positions
  localparam int W_BIT = 0;
  localparam int D_BIT = 1;
  localparam int S_BIT = 1;

  localparam logic [1:0] MOD_NO_DISP  = 2'h0;
  localparam logic [1:0] MOD_DISP8    = 2'h1;
  localparam logic [1:0] MOD_REG      = 2'h3;
  localparam logic [2:0] RM_DIRECT    = 3'h6;
  localparam logic [1:0] SW_WORD_IMM  = 2'h1;
  localparam logic [1:0] SW_SEXT_IMM  = 2'h3;
  localparam logic [1:0] LEN_NONE     = 2'h0;
  localparam logic [1:0] LEN_ONE      = 2'h1;
  localparam logic [1:0] LEN_TWO      = 2'h2;

  // extension codes in the middle field of the addressing-form byte
  localparam logic [2:0] EXT_SUM      = 3'h0;
  localparam logic [2:0] EXT_CARRY    = 3'h2;
  localparam logic [2:0] EXT_BORROW   = 3'h3;
  localparam logic [2:0] EXT_MINUS    = 3'h5;
  localparam logic [2:0] EXT_COMPARE  = 3'h7;
  localparam logic [2:0] EXT_UPROD    = 3'h4;
  localparam logic [2:0] EXT_SPROD    = 3'h5;
  localparam logic [2:0] EXT_UQUOT    = 3'h6;
  localparam logic [2:0] EXT_SQUOT    = 3'h7;

  localparam logic [7:0] ASCII_FIX_SECOND = 8'h0A;
  localparam int         MAX_INST_LEN     = 6;

  // opcode patterns; a family is its first code plus the span of codes above it
  localparam logic [7:0] SPAN_RM          = 8'h03;
  localparam logic [7:0] SPAN_ACC         = 8'h01;
  localparam logic [7:0] OPC_SUM_RM       = 8'h00;
  localparam logic [7:0] OPC_SUM_ACC      = 8'h04;
  localparam logic [7:0] OPC_CARRY_RM     = 8'h10;
  localparam logic [7:0] OPC_CARRY_ACC    = 8'h14;
  localparam logic [7:0] OPC_BORROW_RM    = 8'h18;
  localparam logic [7:0] OPC_BORROW_ACC   = 8'h1C;
  localparam logic [7:0] OPC_MINUS_RM     = 8'h28;
  localparam logic [7:0] OPC_MINUS_ACC    = 8'h2C;
  localparam logic [7:0] OPC_CMP_RM       = 8'h38;
  localparam logic [7:0] OPC_CMP_ACC      = 8'h3C;
  localparam logic [7:0] OPC_IMM_GRP      = 8'h80;
  localparam logic [7:0] OPC_PROD_QUOT    = 8'hF6;
  localparam logic [7:0] OPC_ASCII_PROD   = 8'hD4;
  localparam logic [7:0] OPC_ASCII_QUOT   = 8'hD5;
  localparam logic [7:0] OPC_ASCII_SUM    = 8'h37;
  localparam logic [7:0] OPC_BCD_SUM      = 8'h27;
  localparam logic [7:0] OPC_ASCII_MINUS  = 8'h3F;
  localparam logic [7:0] OPC_BCD_MINUS    = 8'h2F;
  localparam logic [7:0] OPC_BYTE_WIDEN   = 8'h98;
  localparam logic [7:0] OPC_WORD_WIDEN   = 8'h99;
  localparam logic [7:0] OPC_LOOKUP       = 8'hD7;
  localparam logic [7:0] OPC_EA_LOAD      = 8'h8D;
  localparam logic [7:0] OPC_FAR_DATA_SEG = 8'hC5;
  localparam logic [7:0] OPC_FAR_EXTRA    = 8'hC4;
  localparam logic [7:0] OPC_FLAGS_TO_AH  = 8'h9F;
  localparam logic [7:0] OPC_AH_TO_FLAGS  = 8'h9E;
  localparam logic [7:0] OPC_SEG_TO_RM    = 8'h8C;
  localparam logic [7:0] OPC_RM_TO_SEG    = 8'h8E;

  // displacement bytes implied by an addressing-form byte
  function automatic logic [1:0] disp_len_f(input logic [7:0] modrm);
    logic [1:0] n;
    n = LEN_NONE;
    if (modrm[7:6] == MOD_NO_DISP && modrm[2:0] == RM_DIRECT) begin
      n = LEN_TWO;
    end else if (modrm[7:6] == MOD_DISP8) begin
      n = LEN_ONE;
    end else if (modrm[7:6] != MOD_REG && modrm[7:6] != MOD_NO_DISP) begin
      n = LEN_TWO;
    end
    return n;
  endfunction

endpackage

// [verilog/opcode_class_if.sv]
// interface: opcode and addressing byte out, classification back
`timescale 1ns/1ns
interface opcode_class_if;
  import cpu_decode_pkg::*;
  logic [7:0] opcode;
  logic [7:0] modrm;
  op_e        op;
  logic       needs_modrm;
  logic       fixed_second;
  logic [1:0] disp_len;
  logic [1:0] imm_len;
  logic       size_sel;
  logic       to_reg;
  logic       sext;
  logic       rm_is_reg;

  modport requester (output opcode, modrm, input op, needs_modrm, fixed_second,
                     disp_len, imm_len, size_sel, to_reg, sext, rm_is_reg);
  modport classifier (input opcode, modrm, output op, needs_modrm, fixed_second,
                      disp_len, imm_len, size_sel, to_reg, sext, rm_is_reg);
endinterface

// [verilog/opcode_classifier.sv]
// combinational classifier of one opcode byte and its addressing byte
`timescale 1ns/1ns
module opcode_classifier (
  opcode_class_if.classifier cls
);
  import cpu_decode_pkg::*;

  logic [1:0] acc_len;

  // accumulator immediate forms carry a second byte only for words
  assign acc_len = cls.opcode[W_BIT] ? LEN_TWO : LEN_ONE;

  always_comb begin
    cls.op           = OP_ILLEGAL;
    cls.needs_modrm  = 1'b0;
    cls.fixed_second = 1'b0;
    cls.imm_len      = LEN_NONE;
    cls.size_sel     = cls.opcode[W_BIT];
    cls.to_reg       = cls.opcode[D_BIT];
    cls.sext         = 1'b0;
    unique case (cls.opcode) inside
      [OPC_SUM_RM:OPC_SUM_RM+SPAN_RM]: begin
        cls.op          = OP_SUM;
        cls.needs_modrm = 1'b1;
      end
      [OPC_CARRY_RM:OPC_CARRY_RM+SPAN_RM]: begin
        cls.op          = OP_SUM_CARRY;
        cls.needs_modrm = 1'b1;
      end
      [OPC_MINUS_RM:OPC_MINUS_RM+SPAN_RM]: begin
        cls.op          = OP_MINUS;
        cls.needs_modrm = 1'b1;
      end
      [OPC_BORROW_RM:OPC_BORROW_RM+SPAN_RM]: begin
        cls.op          = OP_MINUS_BORROW;
        cls.needs_modrm = 1'b1;
      end
      [OPC_CMP_RM:OPC_CMP_RM+SPAN_RM]: begin
        cls.op          = OP_COMPARE;
        cls.needs_modrm = 1'b1;
      end
      [OPC_SUM_ACC:OPC_SUM_ACC+SPAN_ACC], [OPC_CARRY_ACC:OPC_CARRY_ACC+SPAN_ACC],
      [OPC_MINUS_ACC:OPC_MINUS_ACC+SPAN_ACC], [OPC_BORROW_ACC:OPC_BORROW_ACC+SPAN_ACC],
      [OPC_CMP_ACC:OPC_CMP_ACC+SPAN_ACC]: begin
        cls.imm_len = acc_len;
        cls.to_reg  = 1'b1;
        unique case (cls.opcode[5:3])
          3'h0:    cls.op = OP_SUM;
          3'h2:    cls.op = OP_SUM_CARRY;
          3'h3:    cls.op = OP_MINUS_BORROW;
          3'h5:    cls.op = OP_MINUS;
          default: cls.op = OP_COMPARE;
        endcase
      end
      [OPC_IMM_GRP:OPC_IMM_GRP+SPAN_RM]: begin
        cls.needs_modrm = 1'b1;
        cls.to_reg      = 1'b0;
        cls.imm_len     = (cls.opcode[S_BIT:W_BIT] == SW_WORD_IMM) ? LEN_TWO : LEN_ONE;
        cls.sext        = (cls.opcode[S_BIT:W_BIT] == SW_SEXT_IMM);
        unique case (cls.modrm[5:3])
          EXT_SUM:     cls.op = OP_SUM;
          EXT_CARRY:   cls.op = OP_SUM_CARRY;
          EXT_BORROW:  cls.op = OP_MINUS_BORROW;
          EXT_MINUS:   cls.op = OP_MINUS;
          EXT_COMPARE: cls.op = OP_COMPARE;
          default:     cls.op = OP_ILLEGAL;
        endcase
      end
      [OPC_PROD_QUOT:OPC_PROD_QUOT+SPAN_ACC]: begin
        cls.needs_modrm = 1'b1;
        unique case (cls.modrm[5:3])
          EXT_UPROD: cls.op = OP_UNSIGNED_PRODUCT;
          EXT_SPROD: cls.op = OP_SIGNED_PRODUCT;
          EXT_UQUOT: cls.op = OP_UNSIGNED_QUOTIENT;
          EXT_SQUOT: cls.op = OP_SIGNED_QUOTIENT;
          default:   cls.op = OP_ILLEGAL;
        endcase
      end
      // a wrong second byte makes the pair illegal rather than a different fix
      OPC_ASCII_PROD: begin
        cls.fixed_second = 1'b1;
        cls.size_sel     = 1'b0;
        cls.op = (cls.modrm == ASCII_FIX_SECOND) ? OP_ASCII_PRODUCT_FIX : OP_ILLEGAL;
      end
      OPC_ASCII_QUOT: begin
        cls.fixed_second = 1'b1;
        cls.op = (cls.modrm == ASCII_FIX_SECOND) ? OP_ASCII_QUOTIENT_FIX : OP_ILLEGAL;
      end
      OPC_ASCII_SUM:   cls.op = OP_ASCII_SUM_FIX;
      OPC_BCD_SUM:     cls.op = OP_BCD_SUM_FIX;
      OPC_ASCII_MINUS: cls.op = OP_ASCII_MINUS_FIX;
      OPC_BCD_MINUS:   cls.op = OP_BCD_MINUS_FIX;
      OPC_BYTE_WIDEN:  cls.op = OP_BYTE_SIGN_WIDEN;
      OPC_WORD_WIDEN:  cls.op = OP_WORD_SIGN_WIDEN;
      OPC_LOOKUP:      cls.op = OP_TABLE_LOOKUP;
      OPC_FLAGS_TO_AH: cls.op = OP_FLAGS_TO_HIGH_ACC;
      OPC_AH_TO_FLAGS: cls.op = OP_HIGH_ACC_TO_FLAGS;
      OPC_EA_LOAD: begin cls.op = OP_EFF_ADDR_LOAD; cls.needs_modrm = 1'b1; end
      OPC_FAR_DATA_SEG: begin
        cls.op = OP_FAR_PTR_LOAD_DATA_SEG; cls.needs_modrm = 1'b1;
      end
      OPC_FAR_EXTRA: begin
        cls.op = OP_FAR_PTR_LOAD_EXTRA_SEG; cls.needs_modrm = 1'b1;
      end
      OPC_SEG_TO_RM: begin cls.op = OP_COPY_SEG_TO_RM; cls.needs_modrm = 1'b1; end
      OPC_RM_TO_SEG: begin cls.op = OP_COPY_RM_TO_SEG; cls.needs_modrm = 1'b1; end
      default:         cls.op = OP_ILLEGAL;
    endcase
  end

  // register operand forms carry no displacement
  assign cls.disp_len  = cls.needs_modrm ? disp_len_f(cls.modrm) : LEN_NONE;
  assign cls.rm_is_reg = cls.needs_modrm && (cls.modrm[7:6] == MOD_REG);

endmodule

// [dv/prefetch_queue_model.sv]
// prefetch queue model: offers queued instruction bytes, optionally pausing
`timescale 1ns/1ns
module prefetch_queue_model (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       stall,
  input  wire logic       byte_ready,
  output logic            byte_valid,
  output logic [7:0]      byte_data
);
  logic [7:0] mem [0:63];
  logic [5:0] head_r;
  logic [5:0] tail_r;
  logic       gap_r;
  logic [7:0] last_r;
  // a gap only follows an accepted byte, so an offer is never withdrawn
  assign byte_valid = (head_r != tail_r) && !gap_r;
  // idle data shows the inverse of the last byte, not a stale copy
  assign byte_data  = byte_valid ? mem[head_r] : ~last_r;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      head_r <= 6'h00;
      tail_r <= 6'h00;
      gap_r  <= 1'b0;
      last_r <= 8'h00;
    end else begin
      gap_r <= stall && byte_valid && byte_ready;
      if (byte_valid && byte_ready) begin
        head_r <= head_r + 6'h01;
        last_r <= mem[head_r];
      end
    end
  end
  task automatic load(input logic [47:0] b, input logic [2:0] n);
    for (int i = 0; i < int'(n); i++) begin
      mem[tail_r + 6'(i)] <= b[47 - 8 * i -: 8];
    end
    tail_r <= tail_r + 6'(n);
  endtask
endmodule

// [dv/test_opcode_decoder.sv]
// testbench of the opcode decoder fed by the prefetch queue model
`timescale 1ns/1ns
module test_opcode_decoder;
  import cpu_decode_pkg::*;
  typedef struct packed {
    logic [47:0] b;
    op_e         op;
    logic [2:0]  len;
    logic        r;
    logic [1:0]  d;
    logic [16:0] imm;
  } row_s;
  localparam int NR = 31;
  localparam row_s ROWS [NR] = '{
    '{48'h00C000000000,OP_SUM,3'h2,1'h1,2'h0,17'h00000},
    '{48'h03C000000000,OP_SUM,3'h2,1'h1,2'h1,17'h00000},
    '{48'h810634127856,OP_SUM,3'h6,1'h0,2'h0,17'h15678},
    '{48'h83C080000000,OP_SUM,3'h3,1'h1,2'h0,17'h1FF80},
    '{48'h80C080000000,OP_SUM,3'h3,1'h1,2'h0,17'h10080},
    '{48'h053412000000,OP_SUM,3'h3,1'h0,2'h1,17'h11234},
    '{48'h041200000000,OP_SUM,3'h2,1'h0,2'h1,17'h10012},
    '{48'h2BC000000000,OP_MINUS,3'h2,1'h1,2'h1,17'h00000},
    '{48'h1A0000000000,OP_MINUS_BORROW,3'h2,1'h0,2'h1,17'h00000},
    '{48'h81E801000000,OP_MINUS,3'h4,1'h1,2'h0,17'h10001},
    '{48'hF7E000000000,OP_UNSIGNED_PRODUCT,3'h2,1'h1,2'h2,17'h00000},
    '{48'hF62E34120000,OP_SIGNED_PRODUCT,3'h4,1'h0,2'h2,17'h00000},
    '{48'hF7F000000000,OP_UNSIGNED_QUOTIENT,3'h2,1'h1,2'h2,17'h00000},
    '{48'hF6F800000000,OP_SIGNED_QUOTIENT,3'h2,1'h1,2'h2,17'h00000},
    '{48'hD40A00000000,OP_ASCII_PRODUCT_FIX,3'h2,1'h0,2'h2,17'h00000},
    '{48'hD50A00000000,OP_ASCII_QUOTIENT_FIX,3'h2,1'h0,2'h2,17'h00000},
    '{48'h2F0000000000,OP_BCD_MINUS_FIX,3'h1,1'h0,2'h2,17'h00000},
    '{48'h980000000000,OP_BYTE_SIGN_WIDEN,3'h1,1'h0,2'h2,17'h00000},
    '{48'h990000000000,OP_WORD_SIGN_WIDEN,3'h1,1'h0,2'h2,17'h00000},
    '{48'h370000000000,OP_ASCII_SUM_FIX,3'h1,1'h0,2'h2,17'h00000},
    '{48'h270000000000,OP_BCD_SUM_FIX,3'h1,1'h0,2'h2,17'h00000},
    '{48'h3F0000000000,OP_ASCII_MINUS_FIX,3'h1,1'h0,2'h2,17'h00000},
    '{48'hD70000000000,OP_TABLE_LOOKUP,3'h1,1'h0,2'h2,17'h00000},
    '{48'h8D4610000000,OP_EFF_ADDR_LOAD,3'h3,1'h0,2'h2,17'h00000},
    '{48'hC58734120000,OP_FAR_PTR_LOAD_DATA_SEG,3'h4,1'h0,2'h2,17'h00000},
    '{48'hC40700000000,OP_FAR_PTR_LOAD_EXTRA_SEG,3'h2,1'h0,2'h2,17'h00000},
    '{48'h9F0000000000,OP_FLAGS_TO_HIGH_ACC,3'h1,1'h0,2'h2,17'h00000},
    '{48'h9E0000000000,OP_HIGH_ACC_TO_FLAGS,3'h1,1'h0,2'h2,17'h00000},
    '{48'h8CD800000000,OP_COPY_SEG_TO_RM,3'h2,1'h1,2'h2,17'h00000},
    '{48'h8E1E34120000,OP_COPY_RM_TO_SEG,3'h4,1'h0,2'h2,17'h00000},
    '{48'hD40500000000,OP_ILLEGAL,3'h2,1'h0,2'h2,17'h00000}
  };
  logic        ref_clk;
  logic        reset_n;
  logic        stall;
  logic        byte_valid;
  logic [7:0]  byte_data;
  logic        byte_ready;
  logic        inst_valid;
  op_e         inst_op;
  logic        size_sel;
  logic        to_reg_flag;
  logic        rm_is_reg;
  logic [15:0] imm_value;
  logic [2:0]  inst_len;
  logic [1:0]  addr_form_field;
  logic [2:0]  gpr_select_field;
  logic [2:0]  operand_locator_field;
  logic [1:0]  seg_sel;
  logic [15:0] disp_value;
  logic        imm_sign_extended;
  int          err_count = 0;
  int          samples_checked = 0;
  opcode_decoder i_opcode_decoder (.ref_clk(ref_clk), .reset_n(reset_n),
    .byte_valid(byte_valid), .byte_data(byte_data), .byte_ready(byte_ready),
    .inst_valid(inst_valid), .inst_op(inst_op), .size_sel(size_sel),
    .to_reg_flag(to_reg_flag), .rm_is_reg(rm_is_reg), .addr_form_field(addr_form_field),
    .gpr_select_field(gpr_select_field), .operand_locator_field(operand_locator_field),
    .seg_sel(seg_sel), .disp_value(disp_value), .imm_value(imm_value),
    .imm_sign_extended(imm_sign_extended), .inst_len(inst_len));
  prefetch_queue_model i_prefetch_queue_model (.ref_clk(ref_clk), .reset_n(reset_n),
    .stall(stall), .byte_ready(byte_ready), .byte_valid(byte_valid), .byte_data(byte_data));
  always #5 ref_clk = ~ref_clk;
  task automatic chk_op(input op_e got, input op_e exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t op %s expected %s", $time, got.name(), exp.name());
    end
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // bounded wait for the result pulse, then look at it in its own cycle
  task automatic wait_valid;
    for (int k = 0; k < 20; k++) begin
      @(posedge ref_clk);
      #1;
      if (inst_valid === 1'b1) break;
    end
    chk_val(16'(inst_valid), 16'h0001, "valid");
    chk_val(16'(byte_ready), 16'h0000, "ready during result");
  endtask
  task automatic run_row(input row_s rw);
    // accumulator immediate forms carry no addressing byte
    logic [7:0] m;
    m = (rw.b[47:46] == 2'h0 && rw.b[42]) ? 8'h00 : rw.b[39:32];
    i_prefetch_queue_model.load(rw.b, rw.len);
    wait_valid();
    chk_op(inst_op, rw.op);
    chk_val(16'(size_sel), 16'(rw.b[40]), "size");
    chk_val(16'(rm_is_reg), 16'(rw.r), "reg form");
    chk_val(16'(inst_len), 16'(rw.len), "length");
    if (rw.d != 2'h2) chk_val(16'(to_reg_flag), 16'(rw.d), "direction");
    if (rw.imm[16]) chk_val(imm_value, rw.imm[15:0], "immediate");
    chk_val(16'(addr_form_field), 16'(m[7:6]), "form");
    chk_val(16'(gpr_select_field), 16'(m[5:3]), "reg field");
    chk_val(16'(operand_locator_field), 16'(m[2:0]), "locator");
    chk_val(16'(seg_sel), 16'(m[4:3]), "segment");
    chk_val(16'(imm_sign_extended), 16'(rw.b[47:40] == 8'h83), "sign flag");
  endtask
  initial begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    stall = 1'b0;
    repeat (7) @(posedge ref_clk);
    #1;
    chk_val(16'(byte_ready), 16'h0000, "ready in reset");
    chk_op(inst_op, OP_ILLEGAL);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    for (int i = 0; i < NR; i++) begin
      stall <= (i > NR / 2);
      run_row(ROWS[i]);
      $display("row %0d done", i);
    end
    // two single-byte instructions queued together: the second waits out the refusal
    i_prefetch_queue_model.load(48'h989900000000, 3'h2);
    wait_valid();
    chk_op(inst_op, OP_BYTE_SIGN_WIDEN);
    wait_valid();
    chk_op(inst_op, OP_WORD_SIGN_WIDEN);
    chk_val(16'(inst_len), 16'h0001, "length");
    $display("back to back done");
    run_row(ROWS[2]);
    chk_val(disp_value, 16'h1234, "displacement");
    $display("displacement done");
    // reset in mid-instruction must drop the partial bytes
    i_prefetch_queue_model.load(48'h810634000000, 3'h3);
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk_val(16'(inst_len), 16'h0000, "length in reset");
    @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    run_row(ROWS[16]);
    $display("mid reset done");
    finish_test();
  end
  initial begin
    #100000;
    err_count++;
    finish_test();
  end
endmodule
